/* adc_pkg.sv */
package adc_pkg;

  // register offsets (byte index within the converter page)
  localparam logic [3:0] off_data0     = 4'h0;  // data registers 0..7 at 0x0..0x7
  localparam logic [3:0] off_lt6       = 4'h8;
  localparam logic [3:0] off_lt7       = 4'h9;
  localparam logic [3:0] off_ut6       = 4'ha;
  localparam logic [3:0] off_ut7       = 4'hb;
  localparam logic [3:0] off_flags     = 4'hc;
  localparam logic [3:0] off_ctrl      = 4'hd;
  localparam logic [3:0] off_irq_ctrl  = 4'he;
  localparam logic [3:0] off_irq_prio  = 4'hf;

  // control register field positions
  localparam int ctrl_first_lo   = 0;   // first_chan_bit0..2 at [2:0]
  localparam int ctrl_go         = 3;
  localparam int ctrl_cont       = 4;
  localparam int ctrl_pin_en     = 5;
  localparam int ctrl_timer_en   = 6;
  localparam int ctrl_power      = 7;

  // irq control field positions
  localparam int irq_done_pend   = 7;
  localparam int irq_alarm_pend  = 6;
  localparam int irq_done_mask   = 5;
  localparam int irq_alarm_mask  = 4;

  // reset values
  localparam logic [7:0] ctrl_reset     = 8'h00;
  localparam logic [7:0] irq_ctrl_reset = 8'h00;
  localparam logic [2:0] prio_reset     = 3'h7;
  localparam logic [3:0] flags_low_ones = 4'hf;
  localparam logic [2:0] last_chan      = 3'h7;

  // conversion timing in core clock cycles
  localparam logic [7:0] conv_cycles   = 8'd138;
  localparam logic [7:0] sample_cycles = 8'd84;

  typedef enum logic [1:0] {st_idle, st_sample, st_approx} conv_state_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // analog core handshake
  typedef struct packed {
    logic [2:0] chan;
    logic       sample;
    logic       convert;
    logic       power_on;
  } analog_ctl_t;

endpackage

/* adc_autoscan_sequencer.sv */
`timescale 1ns/100ps
// Summary of operation
// - conversion lasts 138 cycles, 84 sampling
// - every converted channel gives 8-bit result
// - continuous bit set: continuous, else single
// - start at first channel, step up, stop after 7
// - first channel seven converts only channel seven
// - go bit starts scan; result to channel register
// - single: clear go after seven, raise done
// - continuous: restart at first until go cleared
// - done request each time channel seven ends
// - new result overwrites channel data register
// - pin and timer triggers, enabled, then ored
// - trigger sets go; later pulses ignored
// - trigger while go set is ignored
// - channels 6,7 window check sets flag, alarm
// - four thresholds at offsets 08h to 0Bh
// - flags in upper four bits, lower read one
// - flags cleared by reset, alarm clear or zero write to flags
// - power resets off, forced off in halt
// - two maskable requests, fixed and level priority
// - alarm served first, done stays pending
// - software setting pending flag raises request
// - control write aborts and reinitialises scan
module adc_autoscan_sequencer (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // register port
  input  wire adc_pkg::reg_req_t    req,
  output logic [7:0]                rdata,
  // trigger sources, active low
  input  wire logic                 pin_trigger_n,
  input  wire logic                 timer_trigger_n,
  // processor halt
  input  wire logic                 halt,
  // analog core
  output adc_pkg::analog_ctl_t      analog_ctl,
  input  wire logic [7:0]           analog_result,
  // interrupt requests
  output logic                      sequence_done_irq,
  output logic                      window_alarm_irq,
  output logic [2:0]                irq_level
);

  logic [7:0]                data_reg [8];
  logic [7:0]                lt6_reg, lt7_reg, ut6_reg, ut7_reg;
  logic [3:0]                flags_reg;
  logic [7:0]                ctrl_reg;
  logic [7:0]                irq_ctrl_reg;
  logic [2:0]                prio_reg;
  adc_pkg::conv_state_t      state_reg;
  logic [7:0]                cnt_reg;
  logic [2:0]                chan_reg;
  logic [1:0]                pin_sync_reg, timer_sync_reg;
  logic                      pin_prev_reg, timer_prev_reg;
  logic                      conv_end, last_end, start_evt, trig_evt;
  logic                      ctrl_wr, irq_wr;
  logic [3:0]                flag_hits;
  logic [7:0]                rdata_next;

  assign ctrl_wr = req.wr && (req.addr == adc_pkg::off_ctrl);
  assign irq_wr  = req.wr && (req.addr == adc_pkg::off_irq_ctrl);

  // pin trigger synchroniser; edge detect only on the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_sync_reg <= 2'h3;
      pin_prev_reg <= 1'b1;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], pin_trigger_n};
      pin_prev_reg <= pin_sync_reg[1];
    end
  end

  // timer trigger synchroniser; idle-high reset avoids a false edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_sync_reg <= 2'h3;
      timer_prev_reg <= 1'b1;
    end else begin
      timer_sync_reg <= {timer_sync_reg[0], timer_trigger_n};
      timer_prev_reg <= timer_sync_reg[1];
    end
  end

  // falling edge only, so a long low pulse starts one scan
  assign trig_evt =
    (ctrl_reg[adc_pkg::ctrl_pin_en] && pin_prev_reg && !pin_sync_reg[1]) ||
    (ctrl_reg[adc_pkg::ctrl_timer_en] && timer_prev_reg && !timer_sync_reg[1]);
  // triggers count only while go is clear
  assign start_evt = trig_evt && !ctrl_reg[adc_pkg::ctrl_go];

  assign conv_end = (state_reg == adc_pkg::st_approx)
                 && (cnt_reg == adc_pkg::conv_cycles - 8'd1);
  assign last_end = conv_end && (chan_reg == adc_pkg::last_chan);

  // control register: software write, trigger set, hardware clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= adc_pkg::ctrl_reset;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= req.wdata;
      end else if (start_evt) begin
        ctrl_reg[adc_pkg::ctrl_go] <= 1'b1;
      end else if (last_end && !ctrl_reg[adc_pkg::ctrl_cont]) begin
        ctrl_reg[adc_pkg::ctrl_go] <= 1'b0;
      end
      if (halt) begin
        ctrl_reg[adc_pkg::ctrl_power] <= 1'b0;
      end
    end
  end

  // scan sequencer; any control write aborts and restarts from idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= adc_pkg::st_idle;
      cnt_reg   <= 8'h00;
      chan_reg  <= 3'h0;
    end else if (ctrl_wr) begin
      state_reg <= adc_pkg::st_idle;
      cnt_reg   <= 8'h00;
      chan_reg  <= req.wdata[2:0];
    end else begin
      case (state_reg)
        adc_pkg::st_idle: begin
          cnt_reg  <= 8'h00;
          chan_reg <= ctrl_reg[2:0];
          if (ctrl_reg[adc_pkg::ctrl_go]) begin
            state_reg <= adc_pkg::st_sample;
          end
        end
        adc_pkg::st_sample: begin
          cnt_reg <= cnt_reg + 8'd1;
          if (cnt_reg == adc_pkg::sample_cycles - 8'd1) begin
            state_reg <= adc_pkg::st_approx;
          end
        end
        adc_pkg::st_approx: begin
          cnt_reg <= cnt_reg + 8'd1;
          if (conv_end) begin
            cnt_reg <= 8'h00;
            if (!last_end) begin
              chan_reg  <= chan_reg + 3'h1;
              state_reg <= adc_pkg::st_sample;
            end else if (ctrl_reg[adc_pkg::ctrl_cont]) begin
              chan_reg  <= ctrl_reg[2:0];
              state_reg <= adc_pkg::st_sample;
            end else begin
              state_reg <= adc_pkg::st_idle;
            end
          end
        end
        default: state_reg <= adc_pkg::st_idle;
      endcase
    end
  end

  // per-channel result registers, overwritten on every conversion
  for (genvar i = 0; i < 8; i++) begin : g_data
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        data_reg[i] <= 8'h00;
      end else if (conv_end && chan_reg == 3'(i)) begin
        data_reg[i] <= analog_result;
      end else if (req.wr && req.addr == adc_pkg::off_data0 + 4'(i)) begin
        data_reg[i] <= req.wdata;
      end
    end
  end

  // lower threshold of channel 6; reset value raises no alarm
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lt6_reg <= 8'h00;
    end else if (req.wr && req.addr == adc_pkg::off_lt6) begin
      lt6_reg <= req.wdata;
    end
  end

  // lower threshold of channel 7
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lt7_reg <= 8'h00;
    end else if (req.wr && req.addr == adc_pkg::off_lt7) begin
      lt7_reg <= req.wdata;
    end
  end

  // upper threshold of channel 6; a full-scale result still trips it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ut6_reg <= 8'hff;
    end else if (req.wr && req.addr == adc_pkg::off_ut6) begin
      ut6_reg <= req.wdata;
    end
  end

  // upper threshold of channel 7
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ut7_reg <= 8'hff;
    end else if (req.wr && req.addr == adc_pkg::off_ut7) begin
      ut7_reg <= req.wdata;
    end
  end

  // window check, bit order: ch7 upper, ch6 upper, ch7 lower, ch6 lower
  always_comb begin
    flag_hits = 4'h0;
    if (conv_end && chan_reg == 3'h6) begin
      flag_hits[2] = analog_result >= ut6_reg;
      flag_hits[0] = analog_result < lt6_reg;
    end
    if (conv_end && chan_reg == 3'h7) begin
      flag_hits[3] = analog_result >= ut7_reg;
      flag_hits[1] = analog_result < lt7_reg;
    end
  end

  // compare flags: a fresh hit wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags_reg <= 4'h0;
    end else begin
      if (irq_wr && !req.wdata[adc_pkg::irq_alarm_pend]) begin
        flags_reg <= flag_hits;
      end else if (req.wr && req.addr == adc_pkg::off_flags) begin
        flags_reg <= (flags_reg & req.wdata[7:4]) | flag_hits;
      end else begin
        flags_reg <= flags_reg | flag_hits;
      end
    end
  end

  // pending flags and masks; hardware set beats software clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_ctrl_reg <= adc_pkg::irq_ctrl_reset;
    end else begin
      if (irq_wr) begin
        irq_ctrl_reg <= req.wdata;
      end
      if (last_end) begin
        irq_ctrl_reg[adc_pkg::irq_done_pend] <= 1'b1;
      end
      if (|flag_hits) begin
        irq_ctrl_reg[adc_pkg::irq_alarm_pend] <= 1'b1;
      end
    end
  end

  // priority level register, seven levels plus zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prio_reg <= adc_pkg::prio_reset;
    end else if (req.wr && req.addr == adc_pkg::off_irq_prio) begin
      prio_reg <= req.wdata[2:0];
    end
  end

  // alarm request: pending and unmasked
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      window_alarm_irq <= 1'b0;
    end else begin
      window_alarm_irq <= irq_ctrl_reg[adc_pkg::irq_alarm_pend]
                       && irq_ctrl_reg[adc_pkg::irq_alarm_mask];
    end
  end

  // done request waits while an alarm is being served
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sequence_done_irq <= 1'b0;
    end else begin
      sequence_done_irq <= irq_ctrl_reg[adc_pkg::irq_done_pend]
                        && irq_ctrl_reg[adc_pkg::irq_done_mask]
                        && !(irq_ctrl_reg[adc_pkg::irq_alarm_pend]
                             && irq_ctrl_reg[adc_pkg::irq_alarm_mask]);
    end
  end

  // level output, one cycle behind the priority register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_level <= adc_pkg::prio_reset;
    end else begin
      irq_level <= prio_reg;
    end
  end

  // analog core controls, registered; power-up delay is software's job
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      analog_ctl <= '0;
    end else begin
      analog_ctl.chan     <= chan_reg;
      analog_ctl.sample   <= state_reg == adc_pkg::st_sample;
      analog_ctl.convert  <= state_reg == adc_pkg::st_approx;
      analog_ctl.power_on <= ctrl_reg[adc_pkg::ctrl_power] && !halt;
    end
  end

  // read mux: zero unless a read strobe is present
  always_comb begin
    rdata_next = 8'h00;
    if (req.rd) begin
      case (req.addr)
        adc_pkg::off_lt6:      rdata_next = lt6_reg;
        adc_pkg::off_lt7:      rdata_next = lt7_reg;
        adc_pkg::off_ut6:      rdata_next = ut6_reg;
        adc_pkg::off_ut7:      rdata_next = ut7_reg;
        adc_pkg::off_flags:    rdata_next = {flags_reg, adc_pkg::flags_low_ones};
        adc_pkg::off_ctrl:     rdata_next = ctrl_reg;
        adc_pkg::off_irq_ctrl: rdata_next = irq_ctrl_reg;
        adc_pkg::off_irq_prio: rdata_next = {5'h00, prio_reg};
        default:               rdata_next = data_reg[req.addr[2:0]];
      endcase
    end
  end

  // read data stands one cycle after the strobe, straight from a flop
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule

/* adc_autoscan_sequencer_monitor.sv */
`timescale 1ns/100ps
module adc_autoscan_sequencer_monitor (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rst_n,
  // register port
  input wire adc_pkg::reg_req_t    req,
  input wire logic [7:0]           rdata,
  // triggers and halt
  input wire logic                 pin_trigger_n,
  input wire logic                 timer_trigger_n,
  input wire logic                 halt,
  // analog core
  input wire adc_pkg::analog_ctl_t analog_ctl,
  input wire logic [7:0]           analog_result,
  // interrupt side
  input wire logic                 sequence_done_irq,
  input wire logic                 window_alarm_irq,
  input wire logic [2:0]           irq_level
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [7:0] samp_cnt;
  logic [7:0] conv_cnt;
  logic [3:0] wr_hist;
  wire        ctl_wr = req.wr && req.addr == adc_pkg::off_ctrl;

  // phase run lengths; a control write cuts a phase short, so recent writes are remembered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      samp_cnt <= 8'h00;
      conv_cnt <= 8'h00;
      wr_hist  <= 4'h0;
    end else begin
      samp_cnt <= analog_ctl.sample ? samp_cnt + 8'h01 : 8'h00;
      conv_cnt <= analog_ctl.convert ? conv_cnt + 8'h01 : 8'h00;
      wr_hist  <= {wr_hist[2:0], ctl_wr};
    end
  end

  property p_samp; $rose(analog_ctl.convert) |-> samp_cnt == 8'h54; endproperty
  a_samp: assert property (p_samp) else $error("sample phase length wrong");
  property p_conv; $fell(analog_ctl.convert) && wr_hist == 4'h0 |-> conv_cnt == 8'h36; endproperty
  a_conv: assert property (p_conv) else $error("approx phase length wrong");
  property p_excl; !(analog_ctl.sample && analog_ctl.convert); endproperty
  a_excl: assert property (p_excl) else $error("sample and convert overlap");
  property p_step;
    $changed(analog_ctl.chan) && wr_hist == 4'h0
      |-> analog_ctl.chan == $past(analog_ctl.chan) + 3'h1 || $past(analog_ctl.chan) == 3'h7;
  endproperty
  a_step: assert property (p_step) else $error("channel did not step by one");
  property p_abort; ctl_wr && !req.wdata[3] |-> ##3 !(analog_ctl.sample || analog_ctl.convert);
  endproperty
  a_abort: assert property (p_abort) else $error("control write did not stop scan");
  property p_low; $past(req.rd && req.addr == adc_pkg::off_flags) |-> rdata[3:0] == 4'hf; endproperty
  a_low: assert property (p_low) else $error("flag low nibble not ones");
  property p_prio; window_alarm_irq |-> !sequence_done_irq; endproperty
  a_prio: assert property (p_prio) else $error("done request beside alarm");
  property p_halt; halt [*3] |-> !analog_ctl.power_on; endproperty
  a_halt: assert property (p_halt) else $error("power kept in halt");
  property p_level;
    req.wr && req.addr == adc_pkg::off_irq_prio |-> ##3 irq_level == $past(req.wdata[2:0], 3);
  endproperty
  a_level: assert property (p_level) else $error("priority level not applied");
endmodule

bind adc_autoscan_sequencer adc_autoscan_sequencer_monitor i_mon (.clock, .rst_n, .req, .rdata,
  .pin_trigger_n, .timer_trigger_n, .halt, .analog_ctl, .analog_result, .sequence_done_irq,
  .window_alarm_irq, .irq_level);

/* adc_core_model.sv */
`timescale 1ns/100ps
module adc_core_model (
  // clock
  input wire logic                 clock,
  // converter control and bench offset
  input wire adc_pkg::analog_ctl_t analog_ctl,
  input wire logic [7:0]           offset,
  // result to the sequencer
  output logic [7:0]               analog_result
);
  // result encodes the channel; outside a conversion it toggles so a stale sample never matches
  initial analog_result = 8'h5a;
  always @(posedge clock) begin
    if (analog_ctl.convert) begin
      analog_result <= {analog_ctl.chan, 5'h00} ^ offset;
    end else begin
      analog_result <= ~analog_result;
    end
  end
endmodule

/* test_adc_autoscan_sequencer.sv */
`timescale 1ns/100ps
module test_adc_autoscan_sequencer;
  logic                 clock = 1'b0;
  logic                 rst_n = 1'b0;
  adc_pkg::reg_req_t    req = '0;
  logic [1:0]           trig_n = 2'h3;
  logic                 halt = 1'b0;
  logic [7:0]           offset = 8'h00;
  logic [7:0]           rdata;
  logic [7:0]           analog_result;
  logic [2:0]           irq_level;
  logic                 done_irq;
  logic                 alarm_irq;
  adc_pkg::analog_ctl_t analog_ctl;
  int                   bad_count = 0;
  int                   tests_run = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  adc_autoscan_sequencer i_dut (.clock, .rst_n, .req, .rdata, .pin_trigger_n(trig_n[0]),
    .timer_trigger_n(trig_n[1]), .halt, .analog_ctl, .analog_result,
    .sequence_done_irq(done_irq), .window_alarm_irq(alarm_irq), .irq_level);
  adc_core_model i_core (.clock, .analog_ctl, .offset, .analog_result);

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // one-cycle strobes; read data stands only in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string n);
    @(posedge clock);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 check(n, rdata, exp);
  endtask

  // one source low for two cycles, the other held high
  task automatic pulse(input int s);
    @(posedge clock);
    trig_n <= (s != 0) ? 2'h1 : 2'h2;
    idle(2);
    trig_n <= 2'h3;
  endtask

  task automatic t_reset();
    rd(adc_pkg::off_ctrl, 8'h00, "ctrl");
    rd(adc_pkg::off_flags, 8'h0f, "flags");
    check("level", {5'h00, irq_level}, 8'h07);
    wr(adc_pkg::off_irq_prio, 8'h03);
    idle(3);
    check("level", {5'h00, irq_level}, 8'h03);
    $display("reset test done");
  endtask

  task automatic t_single();
    wr(adc_pkg::off_ut7, 8'he0);
    wr(adc_pkg::off_lt6, 8'hc1);
    wr(adc_pkg::off_irq_ctrl, 8'h30);
    wr(adc_pkg::off_ctrl, 8'h80);
    idle(7500);
    wr(adc_pkg::off_ctrl, 8'h8d);
    idle(418);
    rd(adc_pkg::off_ctrl, 8'h85, "ctrl");
    for (int c = 4; c < 8; c++) begin
      rd(4'(c), c == 4 ? 8'h00 : {3'(c), 5'h00}, "data");
    end
    rd(adc_pkg::off_flags, 8'h9f, "flags");
    rd(adc_pkg::off_irq_ctrl, 8'hf0, "irqctl");
    check("irq", {6'h00, alarm_irq, done_irq}, 8'h02);
    wr(adc_pkg::off_irq_ctrl, 8'h30);
    idle(2);
    rd(adc_pkg::off_flags, 8'h0f, "flags");
    check("irq", {6'h00, alarm_irq, done_irq}, 8'h00);
    wr(adc_pkg::off_irq_ctrl, 8'hb0);
    idle(2);
    check("irq", {6'h00, alarm_irq, done_irq}, 8'h01);
    wr(adc_pkg::off_irq_ctrl, 8'h70);
    idle(2);
    check("irq", {6'h00, alarm_irq, done_irq}, 8'h02);
    wr(adc_pkg::off_irq_ctrl, 8'h30);
    $display("single test done");
  endtask

  task automatic t_cont();
    offset <= 8'h01;
    wr(adc_pkg::off_ctrl, 8'h9e);
    idle(556);
    rd(adc_pkg::off_ctrl, 8'h9e, "ctrl");
    rd(4'h6, 8'hc1, "data");
    rd(4'h7, 8'he1, "data");
    rd(adc_pkg::off_irq_ctrl, 8'hf0, "irqctl");
    wr(adc_pkg::off_ctrl, 8'h96);
    idle(3);
    check("busy", {6'h00, analog_ctl.sample, analog_ctl.convert}, 8'h00);
    wr(adc_pkg::off_irq_ctrl, 8'h30);
    $display("continuous test done");
  endtask

  task automatic t_trig();
    for (int s = 0; s < 2; s++) begin
      offset <= 8'(s + 2);
      wr(adc_pkg::off_ctrl, (s != 0) ? 8'hc7 : 8'ha7);
      pulse(s);
      idle(60);
      pulse(s);
      idle(100);
      check("busy", {6'h00, analog_ctl.sample, analog_ctl.convert}, 8'h00);
      rd(adc_pkg::off_ctrl, (s != 0) ? 8'hc7 : 8'ha7, "ctrl");
      rd(4'h7, 8'he0 ^ 8'(s + 2), "data");
      rd(4'h6, 8'hc1, "data");
    end
    $display("trigger test done");
  endtask

  task automatic t_halt();
    wr(adc_pkg::off_ctrl, 8'h80);
    halt <= 1'b1;
    idle(3);
    check("power", {7'h00, analog_ctl.power_on}, 8'h00);
    halt <= 1'b0;
    rd(adc_pkg::off_ctrl, 8'h00, "ctrl");
    $display("halt test done");
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence after three reset cycles
  initial begin
    idle(3);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_cont();
    t_trig();
    t_halt();
    end_sim();
  end

  // watchdog well beyond the expected run length
  initial begin
    idle(20000);
    bad_count++;
    end_sim();
  end
endmodule
